/* ehp_pkg.sv */
package ehp_pkg;

  // ********************************************************
  // Register map (byte addresses)
  // ********************************************************
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] RESULT_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] EVCLR_OFS  = 8'h0c;

  // ********************************************************
  // Field positions
  // ********************************************************
  localparam int CTRL_MODE_BIT  = 0;
  localparam int CTRL_SPA_BIT   = 1;
  localparam int CTRL_SPB_BIT   = 2;
  localparam int CTRL_HV_BIT    = 3;
  localparam int CTRL_ARC_BIT   = 4;
  localparam int RES_PASS_BIT   = 0;
  localparam int RES_UPPER_BIT  = 1;
  localparam int RES_LOWER_BIT  = 2;
  localparam int RES_CONT_BIT   = 3;
  localparam int RES_MFAULT_BIT = 4;
  localparam int RES_STEP_BIT   = 5;
  localparam int RES_LAST_BIT   = 6;
  localparam int STAT_ST_LSB    = 0;
  localparam int EV_START_BIT   = 4;
  localparam int EV_STOP_BIT    = 5;
  localparam int EV_LOAD_BIT    = 6;
  localparam int STAT_LOCK_BIT  = 8;
  localparam int STAT_GATE_BIT  = 9;
  localparam int STAT_SEL_LSB   = 16;

  // ********************************************************
  // Reset values and responses
  // ********************************************************
  localparam logic [4:0] CTRL_RST    = 5'h00;
  localparam logic [7:0] PRESET_RST  = 8'h00;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int DEBOUNCE_NS   = 5000;
  localparam int DEBOUNCE_CYC  = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    EHP_READY   = 2'b00,
    EHP_TESTING = 2'b01,
    EHP_GUARD   = 2'b10
  } ehp_state_e;

endpackage : ehp_pkg

/* ehp_pin_sync.sv */
`timescale 1ns/100ps
module ehp_pin_sync #(
  parameter int WIDTH   = 1,
  parameter int DEB_CYC = 50
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Pins and clean levels
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);

  localparam int CW = $clog2(DEB_CYC + 1);

  initial begin
    if (WIDTH < 1 || DEB_CYC < 1) begin
      $error("ehp_pin_sync: bad parameters");
    end
  end

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // One debounce counter per line; a new level must stay put DEB_CYC cycles
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic [CW-1:0] cnt_q;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cnt_q        <= '0;
        level_out[i] <= 1'b0;
      end else if (s2_q[i] != s3_q[i] || s3_q[i] == level_out[i]) begin
        cnt_q <= '0;
      end else if (cnt_q == CW'(DEB_CYC - 1)) begin
        cnt_q        <= '0;
        level_out[i] <= s3_q[i];
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

endmodule : ehp_pin_sync

/* ehp_edge_det.sv */
`timescale 1ns/100ps
module ehp_edge_det #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Levels in, one-cycle rise pulses out
  input  wire logic [WIDTH-1:0] level_in,
  output logic      [WIDTH-1:0] rise_out
);

  initial begin
    if (WIDTH < 1) begin
      $error("ehp_edge_det: bad width");
    end
  end

  logic [WIDTH-1:0] prev_q;

  // Prev resets high so a line already on at reset gives no event
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q   <= '1;
      rise_out <= '0;
    end else begin
      prev_q   <= level_in;
      rise_out <= level_in & ~prev_q;
    end
  end

endmodule : ehp_edge_det

/* ehp_handler_port.sv */
`timescale 1ns/100ps
module ehp_handler_port #(
  parameter int AW = 8
) (
  // Clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // AXI4-Lite write channels
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // Controller inputs
  input  wire logic          begin_trigger,
  input  wire logic          halt_trigger,
  input  wire logic          safety_lock_in,
  input  wire logic          external_input_gate,
  input  wire logic [7:0]    preset_select,
  input  wire logic          panel_load_strobe,
  // Controller outputs
  output logic               good_judgment_out,
  output logic               upper_limit_reject_out,
  output logic               lower_limit_reject_out,
  output logic               high_voltage_live_out,
  output logic               withstand_reject_out,
  output logic               insulation_reject_out,
  output logic               withstand_selected_out,
  output logic               insulation_selected_out,
  output logic               step_done_out,
  output logic               sequence_done_out,
  output logic               arc_seen_out,
  output logic               trial_active_out,
  output logic               guard_state_out,
  output logic               contact_fault_out,
  output logic               standby_out,
  output logic               measure_fault_out,
  output logic               spare_output_a,
  output logic               spare_output_b
);

  initial begin
    if (AW < 4) begin
      $error("ehp_handler_port: address too narrow");
    end
  end

  // ********************************************************
  // Input conditioning
  // ********************************************************
  logic [4:0] ctl_lvl;
  logic [7:0] sel_lvl;
  logic [2:0] rise;
  logic       lock_lvl;
  logic       gate_lvl;
  logic       start_ev;
  logic       stop_ev;
  logic       load_ev;

  ehp_pin_sync #(.WIDTH(5), .DEB_CYC(ehp_pkg::DEBOUNCE_CYC)) u_ctl_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin_in    ({external_input_gate, safety_lock_in, panel_load_strobe,
                 halt_trigger, begin_trigger}),
    .level_out (ctl_lvl)
  );

  ehp_pin_sync #(.WIDTH(8), .DEB_CYC(ehp_pkg::DEBOUNCE_CYC)) u_sel_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pin_in    (preset_select),
    .level_out (sel_lvl)
  );

  // Edges only, so a held line never retriggers
  ehp_edge_det #(.WIDTH(3)) u_edges (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .level_in (ctl_lvl[2:0]),
    .rise_out (rise)
  );

  assign lock_lvl = ctl_lvl[3];
  assign gate_lvl = ctl_lvl[4];
  assign start_ev = rise[0] & gate_lvl;
  assign stop_ev  = rise[1];
  assign load_ev  = rise[2] & gate_lvl;

  // ********************************************************
  // AXI4-Lite slave
  // ********************************************************
  logic          aw_full_q;
  logic          w_full_q;
  logic [AW-1:0] aw_addr_q;
  logic [31:0]   w_data_q;
  logic          w_en_q;
  logic          wr_fire;
  logic          wr_ctrl;
  logic          res_wr;
  logic          clr_wr;
  logic          wr_ok;

  assign wr_fire = aw_full_q & w_full_q & ~s_axi_bvalid;
  assign wr_ok   = aw_addr_q[1:0] == 2'h0 && aw_addr_q <= AW'(ehp_pkg::EVCLR_OFS);
  assign wr_ctrl = wr_fire & w_en_q & (aw_addr_q == AW'(ehp_pkg::CTRL_OFS));
  assign res_wr  = wr_fire & w_en_q & (aw_addr_q == AW'(ehp_pkg::RESULT_OFS));
  assign clr_wr  = wr_fire & w_en_q & (aw_addr_q == AW'(ehp_pkg::EVCLR_OFS));

  // Address and data taken in either order; ready drops until the response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      aw_addr_q     <= '0;
      w_data_q      <= '0;
      w_en_q        <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= ehp_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q     <= 1'b1;
        aw_addr_q     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q     <= 1'b1;
        w_data_q     <= s_axi_wdata;
        w_en_q       <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? ehp_pkg::RESP_OKAY : ehp_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ********************************************************
  // Test sequencing
  // ********************************************************
  ehp_pkg::ehp_state_e st_q;
  ehp_pkg::ehp_state_e st_d;

  // Protection outranks everything; stop and the firmware result both end a test
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ehp_pkg::EHP_READY: begin
        if (!lock_lvl) begin
          st_d = ehp_pkg::EHP_GUARD;
        end else if (start_ev) begin
          st_d = ehp_pkg::EHP_TESTING;
        end
      end
      ehp_pkg::EHP_TESTING: begin
        if (!lock_lvl) begin
          st_d = ehp_pkg::EHP_GUARD;
        end else if (stop_ev || res_wr) begin
          st_d = ehp_pkg::EHP_READY;
        end
      end
      ehp_pkg::EHP_GUARD: begin
        if (lock_lvl) begin
          st_d = ehp_pkg::EHP_READY;
        end
      end
      default: st_d = ehp_pkg::EHP_GUARD;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q             <= ehp_pkg::EHP_GUARD;
      trial_active_out <= 1'b0;
      standby_out      <= 1'b0;
      guard_state_out  <= 1'b1;
    end else begin
      st_q             <= st_d;
      trial_active_out <= st_d == ehp_pkg::EHP_TESTING;
      standby_out      <= st_d == ehp_pkg::EHP_READY;
      guard_state_out  <= st_d == ehp_pkg::EHP_GUARD;
    end
  end

  // ********************************************************
  // Control register: mode, voltage, arc, spares
  // ********************************************************
  logic [4:0] ctrl_q;

  // Mode is frozen while a test runs so the mode lines cannot lie
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= ehp_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= w_data_q[4:0];
      if (st_q == ehp_pkg::EHP_TESTING) begin
        ctrl_q[ehp_pkg::CTRL_MODE_BIT] <= ctrl_q[ehp_pkg::CTRL_MODE_BIT];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      withstand_selected_out  <= 1'b1;
      insulation_selected_out <= 1'b0;
      high_voltage_live_out   <= 1'b0;
      arc_seen_out            <= 1'b0;
      spare_output_a          <= 1'b0;
      spare_output_b          <= 1'b0;
    end else begin
      withstand_selected_out  <= ~ctrl_q[ehp_pkg::CTRL_MODE_BIT];
      insulation_selected_out <= ctrl_q[ehp_pkg::CTRL_MODE_BIT];
      high_voltage_live_out   <= ctrl_q[ehp_pkg::CTRL_HV_BIT];
      arc_seen_out            <= ctrl_q[ehp_pkg::CTRL_ARC_BIT];
      spare_output_a          <= ctrl_q[ehp_pkg::CTRL_SPA_BIT];
      spare_output_b          <= ctrl_q[ehp_pkg::CTRL_SPB_BIT];
    end
  end

  // ********************************************************
  // Judgment outputs
  // ********************************************************
  logic res_take;
  logic res_fail;
  logic jclr;

  assign res_take = res_wr & (st_q == ehp_pkg::EHP_TESTING);
  assign res_fail = w_data_q[ehp_pkg::RES_UPPER_BIT] | w_data_q[ehp_pkg::RES_LOWER_BIT];
  assign jclr     = stop_ev | (start_ev & (st_q == ehp_pkg::EHP_READY));

  // A result written with the release edge still lands
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      good_judgment_out      <= 1'b0;
      upper_limit_reject_out <= 1'b0;
      lower_limit_reject_out <= 1'b0;
      withstand_reject_out   <= 1'b0;
      insulation_reject_out  <= 1'b0;
      contact_fault_out      <= 1'b0;
      step_done_out          <= 1'b0;
      sequence_done_out      <= 1'b0;
    end else if (res_take) begin
      good_judgment_out      <= w_data_q[ehp_pkg::RES_PASS_BIT];
      upper_limit_reject_out <= w_data_q[ehp_pkg::RES_UPPER_BIT];
      lower_limit_reject_out <= w_data_q[ehp_pkg::RES_LOWER_BIT];
      withstand_reject_out   <= res_fail & ~ctrl_q[ehp_pkg::CTRL_MODE_BIT];
      insulation_reject_out  <= res_fail & ctrl_q[ehp_pkg::CTRL_MODE_BIT];
      contact_fault_out      <= w_data_q[ehp_pkg::RES_CONT_BIT];
      step_done_out          <= w_data_q[ehp_pkg::RES_STEP_BIT];
      sequence_done_out      <= w_data_q[ehp_pkg::RES_LAST_BIT];
    end else if (jclr) begin
      good_judgment_out      <= 1'b0;
      upper_limit_reject_out <= 1'b0;
      lower_limit_reject_out <= 1'b0;
      withstand_reject_out   <= 1'b0;
      insulation_reject_out  <= 1'b0;
      contact_fault_out      <= 1'b0;
      step_done_out          <= 1'b0;
      sequence_done_out      <= 1'b0;
    end
  end

  // Error flag accepted in any state; the set beats start or stop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      measure_fault_out <= 1'b0;
    end else if (res_wr && w_data_q[ehp_pkg::RES_MFAULT_BIT]) begin
      measure_fault_out <= 1'b1;
    end else if (jclr) begin
      measure_fault_out <= 1'b0;
    end
  end

  // ********************************************************
  // Preset load and sticky events
  // ********************************************************
  logic [7:0] preset_q;
  logic [2:0] ev_q;
  logic [2:0] ev_set;
  logic [2:0] ev_clr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      preset_q <= ehp_pkg::PRESET_RST;
    end else if (load_ev) begin
      preset_q <= sel_lvl;
    end
  end

  assign ev_set = {load_ev, stop_ev, start_ev};
  assign ev_clr = clr_wr ? w_data_q[ehp_pkg::EV_LOAD_BIT:ehp_pkg::EV_START_BIT] : 3'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_q <= 3'h0;
    end else begin
      ev_q <= ev_set | (ev_q & ~ev_clr);
    end
  end

  // ********************************************************
  // Read path
  // ********************************************************
  logic [31:0] rd_mux;
  logic        rd_ok;

  always_comb begin
    rd_mux = 32'h0;
    rd_ok  = 1'b1;
    if (s_axi_araddr == AW'(ehp_pkg::CTRL_OFS)) begin
      rd_mux[4:0] = ctrl_q;
    end else if (s_axi_araddr == AW'(ehp_pkg::STATUS_OFS)) begin
      rd_mux[ehp_pkg::STAT_ST_LSB +: 2]            = st_q;
      rd_mux[ehp_pkg::EV_LOAD_BIT:ehp_pkg::EV_START_BIT] = ev_q;
      rd_mux[ehp_pkg::STAT_LOCK_BIT]               = lock_lvl;
      rd_mux[ehp_pkg::STAT_GATE_BIT]               = gate_lvl;
      rd_mux[ehp_pkg::STAT_SEL_LSB +: 8]           = preset_q;
    end else if (s_axi_araddr != AW'(ehp_pkg::RESULT_OFS) &&
                 s_axi_araddr != AW'(ehp_pkg::EVCLR_OFS)) begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= ehp_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_ok ? ehp_pkg::RESP_OKAY : ehp_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ********************************************************
  // Checks
  // ********************************************************
  a_start_begins_test: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (start_ev && lock_lvl && st_q == ehp_pkg::EHP_READY) |=> trial_active_out
  ) else $error("start edge did not begin a test");

  a_halt_releases: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (stop_ev && !res_take) |=> !good_judgment_out && !upper_limit_reject_out
                              && !lower_limit_reject_out
  ) else $error("halt did not release judgments");

  a_gate_blocks_start: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (!gate_lvl && st_q == ehp_pkg::EHP_READY) |=> st_q != ehp_pkg::EHP_TESTING
  ) else $error("start accepted with gate off");

  a_limit_rejects: assert property (
    @(posedge aclk) disable iff (!aresetn)
    res_take |=> upper_limit_reject_out == $past(w_data_q[ehp_pkg::RES_UPPER_BIT])
             && lower_limit_reject_out == $past(w_data_q[ehp_pkg::RES_LOWER_BIT])
  ) else $error("limit reject outputs wrong");

  a_fail_by_mode: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (res_take && res_fail) |=> withstand_reject_out == withstand_selected_out
                            && insulation_reject_out == insulation_selected_out
  ) else $error("fail output does not match mode");

  a_mode_exclusive: assert property (
    @(posedge aclk) disable iff (!aresetn)
    withstand_selected_out != insulation_selected_out
  ) else $error("mode outputs not exclusive");

  a_lock_forces_guard: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !lock_lvl |=> guard_state_out ##1 (guard_state_out || lock_lvl)
  ) else $error("lock low did not force protection");

  a_standby_tracks: assert property (
    @(posedge aclk) disable iff (!aresetn)
    standby_out == (st_q == ehp_pkg::EHP_READY)
  ) else $error("standby does not match ready state");

  a_load_takes_index: assert property (
    @(posedge aclk) disable iff (!aresetn)
    load_ev |=> preset_q == $past(sel_lvl)
  ) else $error("preset index not loaded");

  a_fault_holds: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (measure_fault_out && !jclr) |=> measure_fault_out
  ) else $error("measure fault dropped early");

endmodule : ehp_handler_port

/* ehp_plc_model.sv */
`timescale 1ns/100ps
module ehp_plc_model (
  // Clock
  input  wire logic aclk,
  // Controller lines
  output logic       begin_trigger,
  output logic       halt_trigger,
  output logic       safety_lock_in,
  output logic       external_input_gate,
  output logic [7:0] preset_select,
  output logic       panel_load_strobe
);
  initial begin
    {begin_trigger, halt_trigger, panel_load_strobe} = 3'h0;
    {safety_lock_in, external_input_gate, preset_select} = 10'h000;
  end

  // Every level held 70 cycles, beyond the 50 the debounce needs
  task levels(input logic lock, input logic gate, input logic [7:0] sel);
    @(posedge aclk);
    safety_lock_in <= lock;
    external_input_gate <= gate;
    preset_select <= sel;
    repeat (70) @(posedge aclk);
    #1;
  endtask : levels

  // Short widths model a bouncing contact
  task pulse(input int which, input int n);
    @(posedge aclk);
    begin_trigger <= (which == 0);
    halt_trigger <= (which == 1);
    panel_load_strobe <= (which == 2);
    repeat (n) @(posedge aclk);
    begin_trigger <= 1'b0;
    halt_trigger <= 1'b0;
    panel_load_strobe <= 1'b0;
    repeat (70) @(posedge aclk);
    #1;
  endtask : pulse
endmodule : ehp_plc_model

/* tb.sv */
`timescale 1ns/100ps
module tb;
  logic        aclk = 1'b0;
  logic        aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, preset_select;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, begin_trigger, halt_trigger, safety_lock_in, external_input_gate;
  logic        panel_load_strobe, good_judgment_out, upper_limit_reject_out;
  logic        lower_limit_reject_out, high_voltage_live_out, withstand_reject_out;
  logic        insulation_reject_out, withstand_selected_out, insulation_selected_out;
  logic        step_done_out, sequence_done_out, arc_seen_out, trial_active_out;
  logic        guard_state_out, contact_fault_out, standby_out, measure_fault_out;
  logic        spare_output_a, spare_output_b;
  int          err_count = 0;
  int          checks_done = 0;

  ehp_handler_port ehp_handler_port_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .begin_trigger, .halt_trigger, .safety_lock_in,
    .external_input_gate, .preset_select, .panel_load_strobe, .good_judgment_out,
    .upper_limit_reject_out, .lower_limit_reject_out, .high_voltage_live_out,
    .withstand_reject_out, .insulation_reject_out, .withstand_selected_out,
    .insulation_selected_out, .step_done_out, .sequence_done_out, .arc_seen_out,
    .trial_active_out, .guard_state_out, .contact_fault_out, .standby_out, .measure_fault_out,
    .spare_output_a, .spare_output_b);
  ehp_plc_model ehp_plc_model_i (.aclk, .begin_trigger, .halt_trigger, .safety_lock_in,
    .external_input_gate, .preset_select, .panel_load_strobe);

  always #50 aclk = ~aclk;

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // Outputs follow the register one cycle after the write lands
    repeat (2) @(posedge aclk);
    #1;
  endtask : axi_wr

  task axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task tally_and_finish;
    if (err_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    tally_and_finish();
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h00000;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hf;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    check({guard_state_out, standby_out, withstand_selected_out}, 3'h5);
    ehp_plc_model_i.levels(1'b1, 1'b1, 8'h00);
    check({guard_state_out, standby_out}, 2'h1);
    axi_rd(ehp_pkg::STATUS_OFS);
    check(rd[9:0], 10'h300);
    axi_wr(ehp_pkg::CTRL_OFS, 32'h0000001f);
    check({high_voltage_live_out, arc_seen_out, insulation_selected_out, withstand_selected_out,
           spare_output_a, spare_output_b}, 6'h3b);
    // Bounce shorter than the debounce window gives no start
    ehp_plc_model_i.pulse(0, 10);
    check({trial_active_out, standby_out}, 2'h1);
    ehp_plc_model_i.pulse(0, 70);
    check({trial_active_out, standby_out}, 2'h2);
    // Sticky start event, then cleared by a write of one
    axi_rd(ehp_pkg::STATUS_OFS);
    check(rd[6:0], 7'h11);
    axi_wr(ehp_pkg::EVCLR_OFS, 32'h00000010);
    axi_rd(ehp_pkg::STATUS_OFS);
    check(rd[6:0], 7'h01);
    axi_wr(ehp_pkg::RESULT_OFS, 32'h00000062);
    check({good_judgment_out, upper_limit_reject_out, lower_limit_reject_out,
           withstand_reject_out, insulation_reject_out, step_done_out, sequence_done_out,
           trial_active_out}, 8'h4e);
    ehp_plc_model_i.levels(1'b1, 1'b0, 8'h5a);
    ehp_plc_model_i.pulse(0, 70);
    check({trial_active_out, standby_out}, 2'h1);
    axi_wr(ehp_pkg::RESULT_OFS, 32'h00000010);
    check({measure_fault_out, upper_limit_reject_out}, 2'h3);
    ehp_plc_model_i.pulse(1, 70);
    check({upper_limit_reject_out, insulation_reject_out, step_done_out, sequence_done_out,
           measure_fault_out}, 5'h00);
    ehp_plc_model_i.pulse(2, 70);
    axi_rd(ehp_pkg::STATUS_OFS);
    check(rd[23:16], 8'h00);
    ehp_plc_model_i.levels(1'b1, 1'b1, 8'ha5);
    ehp_plc_model_i.pulse(2, 70);
    axi_rd(ehp_pkg::STATUS_OFS);
    check(rd[23:16], 8'ha5);
    axi_wr(ehp_pkg::CTRL_OFS, 32'h00000000);
    ehp_plc_model_i.pulse(0, 70);
    axi_wr(ehp_pkg::RESULT_OFS, 32'h0000000c);
    check({lower_limit_reject_out, withstand_reject_out, insulation_reject_out,
           contact_fault_out, high_voltage_live_out}, 5'h1a);
    ehp_plc_model_i.pulse(0, 70);
    check({trial_active_out, lower_limit_reject_out, contact_fault_out}, 3'h4);
    axi_wr(ehp_pkg::RESULT_OFS, 32'h00000001);
    check({good_judgment_out, standby_out}, 2'h3);
    axi_rd(8'h10);
    check(rsp, ehp_pkg::RESP_SLVERR);
    axi_wr(8'h14, 32'h0000001f);
    check({rsp, high_voltage_live_out}, {ehp_pkg::RESP_SLVERR, 1'b0});
    ehp_plc_model_i.levels(1'b0, 1'b0, 8'h00);
    check({guard_state_out, standby_out}, 2'h2);
    tally_and_finish();
  end
endmodule : tb
